// [rtl/ict_defs.svh]
// Purpose: timing constants for the instruction cycle timing unit
// Assumes: one processor clock at 10 MHz, two-clock operand reads and writes
// Notes: table rows are head, tail, total, reads, prefetches, writes
// Overview of operation
// - counts assume every bus access takes two clocks
// - report total clocks plus included read/prefetch/write counts
// - long variable write: two writes, tail and total +2
// - quick/immediate ALU: register 2 clocks, memory 5
// - immediate forms add immediate fetch and operand fetch
// - decimal add/sub: 4 clocks register, 12 memory
// - extended 2/10 clocks; memory compare 8 clocks
// - single operand register 2; clear/negate/invert memory 4/5
// - decimal negate/set 4/6; test-and-set 6/10
// - shift time fixed except register and extend counts
// - immediate shifts 6 clocks head 4; memory 6
// - register-count shifts follow the quarter-count formula
// - extend rotates follow their own count formulas
// - bit change/clear/set: 6 register, 8 memory
// - bit test 4 or 8 clocks, never writes
`ifndef ICT_DEFS_SVH
`define ICT_DEFS_SVH

`define ICT_CLK_MHZ 10
`define ICT_BUS_CLKS 2
`define ICT_LONG_EXTRA 2
`define ICT_SHIFT_MIN 6
`define ICT_SHIFT_BASE 3
`define ICT_ROX_IMM_BASE 2

`define ICT_ROW_ALU_REG 0, 0, 2, 0, 1, 0
`define ICT_ROW_ALU_MEM 0, 3, 5, 0, 1, 0
`define ICT_ROW_DEC_REG 2, 0, 4, 0, 1, 0
`define ICT_ROW_DEC_MEM 2, 2, 12, 2, 1, 1
`define ICT_ROW_EXT_MEM 2, 2, 10, 2, 1, 1
`define ICT_ROW_MCMP 1, 0, 8, 2, 1, 0
`define ICT_ROW_CLR_MEM 0, 2, 4, 0, 1, 0
`define ICT_ROW_DNEG_MEM 0, 2, 6, 0, 1, 1
`define ICT_ROW_SCC_MEM 2, 2, 6, 0, 1, 1
`define ICT_ROW_TSET_REG 4, 0, 6, 0, 1, 0
`define ICT_ROW_TSET_MEM 1, 0, 10, 0, 1, 1
`define ICT_ROW_SH_IMM 4, 0, 6, 0, 1, 0
`define ICT_ROW_SH_MEM 0, 2, 6, 0, 1, 1
`define ICT_ROW_BIT_REG_IMM 2, 0, 6, 0, 2, 0
`define ICT_ROW_BIT_REG_REG 4, 0, 6, 0, 1, 0
`define ICT_ROW_BIT_MEM_IMM 1, 2, 8, 0, 2, 1
`define ICT_ROW_BIT_MEM_REG 2, 2, 8, 0, 1, 1
`define ICT_ROW_BITTEST_REG_IMM 2, 0, 4, 0, 2, 0
`define ICT_ROW_BITTEST_REG_REG 2, 0, 4, 0, 1, 0
`define ICT_ROW_BITTEST_MEM_IMM 1, 0, 4, 0, 2, 0
`define ICT_ROW_BITTEST_MEM_REG 2, 0, 8, 0, 1, 0

`endif

// [rtl/ict_pkg.sv]
// Purpose: types for the instruction cycle timing unit
// Assumes: nothing beyond the defs header
// Notes: clock totals are 10 bits, head and tail are 8-bit signed, fetch times 8 bits
package ict_pkg;

  typedef enum logic [4:0] {
    move_quick_op, add_quick_op, sub_quick_op, add_immediate_op, sub_immediate_op,
    and_immediate_op, eor_immediate_op, or_immediate_op, compare_immediate_op,
    decimal_add_op, decimal_sub_op, extended_add_op, extended_sub_op, memory_compare_op,
    clear_op, negate_op, negate_extended_op, invert_op, sign_extend_op, test_op,
    decimal_negate_op, set_cond_op, test_and_set_op,
    logical_shift_op, arith_shift_op, plain_rotate_op, rotate_through_extend_op,
    bit_change_op, bit_clear_op, bit_set_op, bit_test_op
  } ict_op_e;

  typedef logic signed [7:0] ict_edge_t;
  typedef logic [9:0] ict_clk_t;
  typedef logic [3:0] ict_cnt_t;

  // one instruction to be timed
  typedef struct packed {
    ict_op_e op;
    logic mem_form;     // destination or operand in memory
    logic imm_src;      // immediate count / bit number, else register
    logic long_op;      // long operand size
    logic [5:0] count;  // shift count for register or immediate counts
    logic [7:0] imm_clks; // immediate operand fetch time
    logic [7:0] ea_clks;  // operand fetch effective address time
  } ict_req_s;

  typedef struct packed {
    ict_edge_t head;
    ict_edge_t tail;
    ict_clk_t total;
    ict_cnt_t reads;
    ict_cnt_t prefetches;
    ict_cnt_t writes;
  } ict_cost_s;

endpackage

// [rtl/ict_cost_table.sv]
// Purpose: combinational cost lookup for one instruction form
// Assumes: request fields stable while sampled
// Notes: effective address times are added only where the forms require them
`timescale 1ns/1ps
`include "ict_defs.svh"
module ict_cost_table
  import ict_pkg::*;
(
  input wire ict_req_s req,
  output ict_cost_s cost
);

  function automatic ict_cost_s mk(input int h, input int t, input int c, input int r,
                                   input int p, input int w);
    ict_cost_s e;
    e.head = ict_edge_t'(h);
    e.tail = ict_edge_t'(t);
    e.total = ict_clk_t'(c);
    e.reads = ict_cnt_t'(r);
    e.prefetches = ict_cnt_t'(p);
    e.writes = ict_cnt_t'(w);
    return e;
  endfunction

  // variable write count: one bus cycle, or two for long with two more clocks
  function automatic ict_cost_s var_write(input ict_cost_s e, input logic lng);
    ict_cost_s v;
    v = e;
    v.writes = lng ? ict_cnt_t'(2) : ict_cnt_t'(1);
    if (lng) begin
      v.tail = e.tail + ict_edge_t'(`ICT_LONG_EXTRA);
      v.total = e.total + ict_clk_t'(`ICT_LONG_EXTRA);
    end
    return v;
  endfunction

  logic [7:0] n;
  logic [7:0] q;
  logic [7:0] m;
  logic [7:0] sh_raw;
  logic [7:0] sh_clk;
  logic [7:0] rox_raw;
  logic [7:0] rox_clk;
  ict_cost_s base;
  logic add_imm;
  logic add_ea;

  // shift formulas; only register counts and extend rotates depend on n
  always_comb begin
    n = {2'h0, req.count};
    q = n >> 2;
    m = n & 8'h03;
    sh_raw = 8'(`ICT_SHIFT_BASE) + q + m + ((q + m + 8'h01) & 8'h01);
    sh_clk = (sh_raw > 8'(`ICT_SHIFT_MIN)) ? sh_raw : 8'(`ICT_SHIFT_MIN);
    if (req.imm_src) begin
      rox_raw = 8'(`ICT_ROX_IMM_BASE) + n + (n & 8'h01);
    end else begin
      rox_raw = 8'(`ICT_SHIFT_BASE) + n + ((n + 8'h01) & 8'h01);
    end
    rox_clk = (rox_raw > 8'(`ICT_SHIFT_MIN)) ? rox_raw : 8'(`ICT_SHIFT_MIN);
  end

  // base row per operation and form
  always_comb begin
    base = mk(`ICT_ROW_ALU_REG);
    add_imm = 1'b0;
    add_ea = req.mem_form;
    unique case (req.op)
      move_quick_op, add_quick_op, sub_quick_op: begin
        base = req.mem_form ? var_write(mk(`ICT_ROW_ALU_MEM), req.long_op)
                            : mk(`ICT_ROW_ALU_REG);
      end
      add_immediate_op, sub_immediate_op, and_immediate_op, eor_immediate_op,
      or_immediate_op, compare_immediate_op: begin
        base = req.mem_form ? var_write(mk(`ICT_ROW_ALU_MEM), req.long_op)
                            : mk(`ICT_ROW_ALU_REG);
        add_imm = 1'b1;
      end
      decimal_add_op, decimal_sub_op: begin
        base = req.mem_form ? mk(`ICT_ROW_DEC_MEM) : mk(`ICT_ROW_DEC_REG);
        add_ea = 1'b0;
      end
      extended_add_op, extended_sub_op: begin
        base = req.mem_form ? mk(`ICT_ROW_EXT_MEM) : mk(`ICT_ROW_ALU_REG);
        add_ea = 1'b0;
      end
      memory_compare_op: begin
        base = mk(`ICT_ROW_MCMP);
        add_ea = 1'b0;
      end
      clear_op: begin
        base = req.mem_form ? var_write(mk(`ICT_ROW_CLR_MEM), req.long_op)
                            : mk(`ICT_ROW_ALU_REG);
      end
      negate_op, negate_extended_op, invert_op: begin
        base = req.mem_form ? var_write(mk(`ICT_ROW_ALU_MEM), req.long_op)
                            : mk(`ICT_ROW_ALU_REG);
      end
      sign_extend_op, test_op: begin
        base = mk(`ICT_ROW_ALU_REG);
      end
      decimal_negate_op: begin
        base = req.mem_form ? mk(`ICT_ROW_DNEG_MEM) : mk(`ICT_ROW_DEC_REG);
      end
      set_cond_op: begin
        base = req.mem_form ? mk(`ICT_ROW_SCC_MEM) : mk(`ICT_ROW_DEC_REG);
      end
      test_and_set_op: begin
        base = req.mem_form ? mk(`ICT_ROW_TSET_MEM) : mk(`ICT_ROW_TSET_REG);
      end
      logical_shift_op, arith_shift_op, plain_rotate_op: begin
        if (req.mem_form) begin
          base = mk(`ICT_ROW_SH_MEM);
        end else if (req.imm_src) begin
          base = mk(`ICT_ROW_SH_IMM);
        end else begin
          base = mk(int'(sh_clk), 0, int'(sh_clk), 0, 1, 0);
        end
      end
      rotate_through_extend_op: begin
        base = req.mem_form ? mk(`ICT_ROW_SH_MEM)
                            : mk(int'(rox_clk), 0, int'(rox_clk), 0, 1, 0);
      end
      bit_change_op, bit_clear_op, bit_set_op: begin
        unique case ({req.mem_form, req.imm_src})
          2'b01: base = mk(`ICT_ROW_BIT_REG_IMM);
          2'b00: base = mk(`ICT_ROW_BIT_REG_REG);
          2'b11: base = mk(`ICT_ROW_BIT_MEM_IMM);
          2'b10: base = mk(`ICT_ROW_BIT_MEM_REG);
        endcase
        add_imm = req.imm_src;
      end
      bit_test_op: begin
        unique case ({req.mem_form, req.imm_src})
          2'b01: base = mk(`ICT_ROW_BITTEST_REG_IMM);
          2'b00: base = mk(`ICT_ROW_BITTEST_REG_REG);
          2'b11: base = mk(`ICT_ROW_BITTEST_MEM_IMM);
          2'b10: base = mk(`ICT_ROW_BITTEST_MEM_REG);
        endcase
        add_imm = req.imm_src;
      end
      default: base = mk(`ICT_ROW_ALU_REG); // unused encodings
    endcase
  end

  // immediate fetch comes first, then operand fetch, then the operation
  always_comb begin
    cost = base;
    cost.total = base.total + (add_imm ? ict_clk_t'(req.imm_clks) : ict_clk_t'(0))
                 + (add_ea ? ict_clk_t'(req.ea_clks) : ict_clk_t'(0));
  end

endmodule

// [rtl/ict_timing.sv]
// Purpose: times one instruction at a time and paces the execution slot
// Assumes: bus interface finishes every read and write in two clocks
// Notes: a new request is taken only when the previous slot has run out
`timescale 1ns/1ps
`include "ict_defs.svh"
module ict_timing
  import ict_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic req_valid,
  input wire ict_req_s req,
  output logic req_ready,
  output logic rsp_valid,
  output ict_cost_s rsp,
  output ict_clk_t overlap,
  output logic busy
);

  ict_cost_s cost;
  ict_cost_s rsp_r, rsp_nxt;
  ict_clk_t overlap_r, overlap_nxt;
  ict_clk_t left_r, left_nxt;
  ict_edge_t prev_tail_r, prev_tail_nxt;
  logic rsp_valid_r, rsp_valid_nxt;
  logic ready_r, ready_nxt;
  logic busy_r, busy_nxt;
  logic take;
  ict_clk_t head_pos;
  ict_clk_t tail_pos;
  ict_clk_t ovl;

  ict_cost_table u_table (
    .req(req),
    .cost(cost)
  );

  // totals already hold bus cycles at two clocks each
  assign take = req_valid && ready_r;

  // overlap of this head with last tail; negative values clip to none
  always_comb begin
    head_pos = cost.head[7] ? ict_clk_t'(0) : ict_clk_t'(cost.head);
    tail_pos = prev_tail_r[7] ? ict_clk_t'(0) : ict_clk_t'(prev_tail_r);
    ovl = (head_pos < tail_pos) ? head_pos : tail_pos;
    if (ovl >= cost.total) begin
      ovl = cost.total - ict_clk_t'(1); // keep at least one clock
    end
  end

  // slot sequencing: report on take, then count down the remaining clocks
  always_comb begin
    rsp_nxt = rsp_r;
    overlap_nxt = overlap_r;
    left_nxt = left_r;
    prev_tail_nxt = prev_tail_r;
    rsp_valid_nxt = 1'b0;
    ready_nxt = ready_r;
    busy_nxt = busy_r;
    if (take) begin
      rsp_nxt = cost;
      overlap_nxt = ovl;
      prev_tail_nxt = cost.tail;
      rsp_valid_nxt = 1'b1;
      left_nxt = cost.total - ovl - ict_clk_t'(1);
      busy_nxt = 1'b1;
      ready_nxt = 1'b0;
    end else if (busy_r) begin
      if (left_r == ict_clk_t'(0)) begin
        busy_nxt = 1'b0;
        ready_nxt = 1'b1;
      end else begin
        left_nxt = left_r - ict_clk_t'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rsp_r <= '0;
      overlap_r <= '0;
      left_r <= '0;
      prev_tail_r <= '0;
      rsp_valid_r <= 1'b0;
      ready_r <= 1'b1;
      busy_r <= 1'b0;
    end else begin
      rsp_r <= rsp_nxt;
      overlap_r <= overlap_nxt;
      left_r <= left_nxt;
      prev_tail_r <= prev_tail_nxt;
      rsp_valid_r <= rsp_valid_nxt;
      ready_r <= ready_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign req_ready = ready_r;
  assign rsp_valid = rsp_valid_r;
  assign rsp = rsp_r;
  assign overlap = overlap_r;
  assign busy = busy_r;

endmodule

// [testbench/ict_timing_asserts.sv]
// Purpose: port checker for the instruction cycle timing unit
// Assumes: one clock, asynchronous active-low reset
// Notes: run_r counts busy cycles so the slot length can be judged
`timescale 1ns/1ps
module ict_timing_asserts
  import ict_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic req_valid,
  input wire ict_req_s req,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire ict_cost_s rsp,
  input wire ict_clk_t overlap,
  input wire logic busy
);
  ict_clk_t run_r;
  ict_clk_t run_nxt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // busy length, restarted by every answer
  always_comb begin
    run_nxt = run_r;
    if (busy && rsp_valid) begin
      run_nxt = 10'h001;
    end else if (busy) begin
      run_nxt = run_r + 10'h001;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      run_r <= 10'h000;
    end else begin
      run_r <= run_nxt;
    end
  end
  a_answer_after_take: assert property (req_valid && req_ready |=> rsp_valid)
    else $error("no answer one cycle after a take");
  a_ready_not_busy: assert property (req_ready != busy)
    else $error("ready and busy agree");
  a_answer_pulse: assert property (rsp_valid |=> !rsp_valid)
    else $error("answer longer than one cycle");
  a_overlap_cap: assert property (rsp_valid |-> overlap < rsp.total)
    else $error("overlap not below total");
  a_bus_two_clock: assert property (rsp_valid |->
      rsp.total >= 2 * (rsp.reads + rsp.prefetches + rsp.writes))
    else $error("total shorter than its bus accesses");
  a_test_no_write: assert property (rsp_valid && $past(req.op) == bit_test_op |->
      rsp.writes == 4'h0)
    else $error("bit test reports a write");
  a_slot_length: assert property ($fell(busy) |-> run_r == rsp.total - overlap)
    else $error("busy length differs from total minus overlap");
  a_answer_holds: assert property (!rsp_valid |-> $stable(rsp))
    else $error("answer changed without a take");
endmodule
bind ict_timing ict_timing_asserts u_chk (.clk(clk), .nrst(nrst), .req_valid(req_valid),
  .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp), .overlap(overlap),
  .busy(busy));

// [testbench/ict_bus_model.sv]
// Purpose: bus interface model that serves the reported accesses
// Assumes: every read, prefetch and write takes two clocks
// Notes: counts finished accesses only, data is not modelled
`timescale 1ns/1ps
module ict_bus_model
  import ict_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic rsp_valid,
  input wire ict_cost_s rsp,
  output logic [15:0] acc_done
);
  logic [5:0] pend_r, pend_nxt;
  logic ph_r, ph_nxt;
  logic [15:0] done_nxt;
  // one access per two clocks; accesses are part of the total
  always_comb begin
    pend_nxt = pend_r;
    ph_nxt = ph_r;
    done_nxt = acc_done;
    if (pend_r != 6'h00) begin
      ph_nxt = !ph_r;
      if (ph_r) begin
        pend_nxt = pend_r - 6'h01;
        done_nxt = acc_done + 16'h0001;
      end
    end
    if (rsp_valid) begin
      pend_nxt = pend_nxt + {2'h0, rsp.reads} + {2'h0, rsp.prefetches} + {2'h0, rsp.writes};
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pend_r <= 6'h00;
      ph_r <= 1'b0;
      acc_done <= 16'h0000;
    end else begin
      pend_r <= pend_nxt;
      ph_r <= ph_nxt;
      acc_done <= done_nxt;
    end
  end
endmodule

// [testbench/ict_timing_test.sv]
// Purpose: self-checking bench for the instruction cycle timing unit
// Assumes: 10 MHz clock, bus model sees every answer
// Notes: expected costs are worked out by hand for each form
`timescale 1ns/1ps
module ict_timing_test
  import ict_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic req_valid = 1'b0;
  ict_req_s req = '0;
  logic req_ready, rsp_valid, busy;
  ict_cost_s rsp;
  ict_clk_t overlap;
  logic [15:0] acc_done;
  int num_errors = 0;
  int comparisons = 0;
  int prev_tail = 0;
  int acc_exp = 0;
  always #50 clk = ~clk;
  ict_timing u_dut (.clk(clk), .nrst(nrst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp), .overlap(overlap), .busy(busy));
  ict_bus_model u_bus (.clk(clk), .nrst(nrst), .rsp_valid(rsp_valid), .rsp(rsp),
    .acc_done(acc_done));
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      $display("[ERR] %s expected %0d seen %0d", s, e, g);
      num_errors++;
    end
  endtask
  // f holds {mem_form, imm_src, long_op}; overlap follows the previous tail
  task automatic do_op(input ict_op_e op, input logic [2:0] f, input int h, input int t,
      input int tot, input int r, input int p, input int w, input logic [5:0] n = 6'h00,
      input logic [7:0] ic = 8'h00, input logic [7:0] ec = 8'h00);
    int ov;
    int k;
    ov = (h < prev_tail) ? h : prev_tail;
    if (ov > tot - 1) ov = tot - 1;
    @(posedge clk);
    req <= '{op: op, mem_form: f[2], imm_src: f[1], long_op: f[0], count: n,
      imm_clks: ic, ea_clks: ec};
    req_valid <= 1'b1;
    k = 0;
    @(negedge clk);
    while (req_ready !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    if (k == 100) begin
      num_errors++;
      complete_run();
    end
    @(posedge clk);
    req_valid <= 1'b0;
    @(negedge clk);
    chk("rsp_valid", 1, rsp_valid);
    chk("head", h, rsp.head);
    chk("tail", t, rsp.tail);
    chk("total", tot, rsp.total);
    chk("reads", r, rsp.reads);
    chk("prefetches", p, rsp.prefetches);
    chk("writes", w, rsp.writes);
    chk("overlap", ov, overlap);
    k = 0;
    while (busy === 1'b1 && k < 100) begin
      k++;
      @(negedge clk);
    end
    chk("busy_len", tot - ov, k);
    if (k == 100) begin
      num_errors++;
      complete_run();
    end
    prev_tail = t;
    acc_exp += r + p + w;
  endtask
  task automatic t_alu();
    ict_op_e ops [6] = '{sub_quick_op, sub_immediate_op, and_immediate_op, eor_immediate_op,
      or_immediate_op, compare_immediate_op};
    do_op(move_quick_op, 3'h0, 0, 0, 2, 0, 1, 0);
    do_op(add_quick_op, 3'h4, 0, 3, 5, 0, 1, 1);
    do_op(compare_immediate_op, 3'h0, 0, 0, 6, 0, 1, 0, 6'h00, 8'h04);
    do_op(compare_immediate_op, 3'h4, 0, 3, 8, 0, 1, 1, 6'h00, 8'h02, 8'h01);
    do_op(add_immediate_op, 3'h5, 0, 5, 14, 0, 1, 2, 6'h00, 8'h04, 8'h03);
    foreach (ops[i]) do_op(ops[i], 3'h0, 0, 0, 2, 0, 1, 0);
    $display("test alu finished");
  endtask
  task automatic t_bcd();
    do_op(decimal_add_op, 3'h0, 2, 0, 4, 0, 1, 0);
    do_op(decimal_sub_op, 3'h4, 2, 2, 12, 2, 1, 1);
    do_op(extended_add_op, 3'h4, 2, 2, 10, 2, 1, 1);
    do_op(extended_sub_op, 3'h0, 0, 0, 2, 0, 1, 0);
    do_op(memory_compare_op, 3'h4, 1, 0, 8, 2, 1, 0);
    $display("test decimal finished");
  endtask
  task automatic t_single();
    ict_op_e ops [6] = '{clear_op, negate_op, negate_extended_op, invert_op, sign_extend_op,
      test_op};
    do_op(clear_op, 3'h5, 0, 4, 6, 0, 1, 2);
    for (int i = 1; i < 4; i++) do_op(ops[i], 3'h4, 0, 3, 5, 0, 1, 1);
    foreach (ops[i]) do_op(ops[i], 3'h0, 0, 0, 2, 0, 1, 0);
    do_op(decimal_negate_op, 3'h0, 2, 0, 4, 0, 1, 0);
    do_op(decimal_negate_op, 3'h4, 0, 2, 6, 0, 1, 1);
    do_op(set_cond_op, 3'h4, 2, 2, 6, 0, 1, 1);
    do_op(set_cond_op, 3'h0, 2, 0, 4, 0, 1, 0);
    do_op(test_and_set_op, 3'h0, 4, 0, 6, 0, 1, 0);
    do_op(test_and_set_op, 3'h4, 1, 0, 10, 0, 1, 1);
    $display("test single finished");
  endtask
  task automatic t_shift();
    ict_op_e ops [3] = '{logical_shift_op, arith_shift_op, plain_rotate_op};
    foreach (ops[i]) do_op(ops[i], 3'h2, 4, 0, 6, 0, 1, 0, 6'h08 - 6'(i));
    do_op(logical_shift_op, 3'h4, 0, 2, 6, 0, 1, 1);
    do_op(arith_shift_op, 3'h0, 6, 0, 6, 0, 1, 0, 6'h00);
    do_op(plain_rotate_op, 3'h0, 22, 0, 22, 0, 1, 0, 6'h3F);
    do_op(logical_shift_op, 3'h0, 8, 0, 8, 0, 1, 0, 6'h07);
    do_op(rotate_through_extend_op, 3'h0, 66, 0, 66, 0, 1, 0, 6'h3F);
    do_op(rotate_through_extend_op, 3'h2, 10, 0, 10, 0, 1, 0, 6'h08);
    do_op(rotate_through_extend_op, 3'h2, 8, 0, 8, 0, 1, 0, 6'h05);
    do_op(rotate_through_extend_op, 3'h4, 0, 2, 6, 0, 1, 1);
    $display("test shift finished");
  endtask
  task automatic t_bit();
    do_op(bit_change_op, 3'h2, 2, 0, 8, 0, 2, 0, 6'h00, 8'h02);
    do_op(bit_clear_op, 3'h0, 4, 0, 6, 0, 1, 0);
    do_op(bit_set_op, 3'h6, 1, 2, 8, 0, 2, 1);
    do_op(bit_change_op, 3'h4, 2, 2, 8, 0, 1, 1);
    do_op(bit_test_op, 3'h2, 2, 0, 4, 0, 2, 0);
    do_op(bit_test_op, 3'h0, 2, 0, 4, 0, 1, 0);
    do_op(bit_test_op, 3'h6, 1, 0, 4, 0, 2, 0);
    do_op(bit_test_op, 3'h4, 2, 0, 8, 0, 1, 0);
    $display("test bit finished");
  endtask
  // main sequence, then wait for the bus model to drain its accesses
  initial begin
    int k;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    t_alu();
    t_bcd();
    t_single();
    t_shift();
    t_bit();
    k = 0;
    while (acc_done !== 16'(acc_exp) && k < 100) begin
      @(negedge clk);
      k++;
    end
    chk("bus_accesses", acc_exp, acc_done);
    complete_run();
  end
endmodule
